/* File: pkg/qpw_pkg.sv */
package qpw_pkg;

  // Array sizes
  localparam int NUM_POTS = 4;
  localparam int NUM_SAVED = 4;
  localparam int NUM_TAPS = 256;
  localparam int POS_W = 8;
  localparam int POT_W = 2;
  localparam int IDX_W = 2;

  // Target address byte: {type[2:0], strap[3:0], rw}
  localparam logic [2:0] DEV_TYPE = 3'h2; // Arbitrary value, not tied to any maker
  localparam int ADDR_RW_BIT = 0;
  localparam int ADDR_STRAP_LSB = 1;
  localparam int ADDR_TYPE_LSB = 5;

  // Command byte: {reserved, op[2:0], pot[1:0], idx[1:0]}
  localparam int CMD_IDX_LSB = 0;
  localparam int CMD_POT_LSB = 2;
  localparam int CMD_OP_LSB = 4;

  // Saved-setting contents after a blanking reset
  localparam logic [7:0] SAVED_BLANK = 8'h80;

  // Command operations
  typedef enum logic [2:0] {
    OP_WIPER = 3'h0,
    OP_SAVED = 3'h1,
    OP_RECALL = 3'h2,
    OP_STORE = 3'h3,
    OP_STEP = 3'h4
  } qpw_op_t;

  // Request kinds passed from the link to the register side
  typedef enum logic {
    REQ_SELECT = 1'b0,
    REQ_WRITE = 1'b1
  } qpw_kind_t;

  typedef struct packed {
    qpw_kind_t kind;
    logic [2:0] op;
    logic [POT_W-1:0] pot;
    logic [IDX_W-1:0] idx;
    logic [POS_W-1:0] data;
  } qpw_req_t;

endpackage

/* File: rtl/qpw_sync2.sv */
`timescale 1ns/1ps
`default_nettype none

module qpw_sync2 #(
  parameter int W = 1
) (
  // Destination clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Asynchronous level in, synchronised level out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end

endmodule

`default_nettype wire

/* File: rtl/qpw_wiper_store.sv */
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Each of four pots has its own 8-bit wiper position register choosing the tap.
// - Each pot has four 8-bit saved settings, sixteen stored bytes in all.
// - All 256 wiper values select distinct taps.
// - Exactly one tap per pot is connected at any time.
// - Power-up copies each pot's first saved setting into its wiper register.
// - All register writes arrive over the serial bus only.
// - Every data bit in or out is clocked by the master's serial clock.
// - Serial data is driven open-drain only.
// - Four strap inputs form the address; respond only on a match.
// - Guard low blocks non-volatile writes; wiper writes still work.
// - Guard high allows all reads and writes, non-volatile included.
// - Read/write both kinds, recall, store and step up/down commands.
module qpw_wiper_store import qpw_pkg::*; (
  // System clock and power-up reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic nv_blank_i,
  // Serial bus, open-drain data
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Address straps and write guard
  input wire logic addr_strap_bit0_i,
  input wire logic addr_strap_bit1_i,
  input wire logic addr_strap_bit2_i,
  input wire logic addr_strap_bit3_i,
  input wire logic wr_guard_n_i,
  // Potentiometer controls
  output logic [NUM_POTS-1:0][POS_W-1:0] wiper_pos_o,
  output logic [NUM_POTS-1:0][NUM_TAPS-1:0] tap_sel_o
);

  // Link state machine
  typedef enum logic [3:0] {
    L_IDLE = 4'h0,
    L_ADDR = 4'h1,
    L_ADDR_ACK = 4'h2,
    L_CMD = 4'h3,
    L_CMD_ACK = 4'h4,
    L_WDATA = 4'h5,
    L_WDATA_ACK = 4'h6,
    L_RDATA = 4'h7,
    L_RACK = 4'h8
  } qpw_lstate_t;

  // Link-side signals (serial clock domain)
  qpw_lstate_t lstate;
  logic start_pend;
  logic start_ack;
  logic start_clr;
  logic [2:0] bit_cnt;
  logic [7:0] rx_sh;
  logic [7:0] rx_byte;
  logic [7:0] tx_sh;
  logic ack_go;
  logic addr_match;
  logic byte_done;
  logic [3:0] strap_s;
  logic req_tgl;
  qpw_req_t req_bus;
  logic ack_tgl_s;
  logic ack_seen;
  logic [7:0] rd_hold;

  // Register-side signals (system clock domain)
  logic guard_n_s;
  logic nv_allow;
  logic req_tgl_s;
  logic req_seen;
  logic req_fire;
  logic ack_tgl;
  logic [7:0] rd_byte;
  logic [POS_W-1:0] saved [NUM_POTS][NUM_SAVED];
  logic [POS_W-1:0] cur_wiper;
  logic [POS_W-1:0] cur_saved;
  logic [POS_W-1:0] next_wiper;
  logic [POS_W-1:0] next_saved;
  logic [7:0] next_rd;
  logic wiper_we;
  logic saved_we;

  // Open-drain: the data output is always low, only the enable moves
  assign sda_o = 1'b0;

  // Straps are static, but still resynchronised on the serial clock
  qpw_sync2 #(.W(4)) u_strap_sync (
    .clk_i(scl_i),
    .rst_i(1'b0),
    .d_i({addr_strap_bit3_i, addr_strap_bit2_i, addr_strap_bit1_i, addr_strap_bit0_i}),
    .q_o(strap_s)
  );

  // Start: data falls while the clock is high; cleared once the link has seen it
  assign start_clr = start_ack | sys_rst_i;

  always_ff @(negedge sda_i or posedge start_clr) begin
    if (start_clr) begin
      start_pend <= 1'b0;
    end else if (scl_i) begin
      start_pend <= 1'b1;
    end
  end

  // Acknowledge the start; stable by protocol at the next clock rise
  always_ff @(posedge scl_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      start_ack <= 1'b0;
    end else begin
      start_ack <= start_pend;
    end
  end

  // Byte assembled at the eighth rise
  assign rx_byte = {rx_sh[6:0], sda_i};
  assign byte_done = !start_pend && (bit_cnt == 3'h7) &&
                     (lstate == L_ADDR || lstate == L_CMD || lstate == L_WDATA);

  // Address match on device type and straps
  assign addr_match = (rx_byte[ADDR_TYPE_LSB +: 3] == DEV_TYPE) &&
                      (rx_byte[ADDR_STRAP_LSB +: 4] == strap_s);

  // Link sequencer, sampling data on the rising serial clock
  always_ff @(posedge scl_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lstate <= L_IDLE;
      bit_cnt <= 3'h0;
      rx_sh <= 8'h00;
      tx_sh <= 8'hff;
      ack_go <= 1'b0;
    end else if (start_pend) begin
      // First rise after a start carries the top address bit
      lstate <= L_ADDR;
      bit_cnt <= 3'h1;
      rx_sh <= {7'h00, sda_i};
      ack_go <= 1'b0;
    end else begin
      unique case (lstate)
        L_IDLE: begin
          ack_go <= 1'b0;
        end
        L_ADDR, L_CMD, L_WDATA: begin
          rx_sh <= rx_byte;
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == 3'h7) begin
            ack_go <= (lstate == L_ADDR) ? addr_match : 1'b1;
            unique case (lstate)
              L_ADDR: lstate <= L_ADDR_ACK;
              L_CMD: lstate <= L_CMD_ACK;
              default: lstate <= L_WDATA_ACK;
            endcase
          end
        end
        L_ADDR_ACK: begin
          ack_go <= 1'b0;
          bit_cnt <= 3'h0;
          if (!ack_go) begin
            lstate <= L_IDLE;
          end else if (rx_sh[ADDR_RW_BIT]) begin
            lstate <= L_RDATA;
            tx_sh <= rd_hold;
          end else begin
            lstate <= L_CMD;
          end
        end
        L_CMD_ACK, L_WDATA_ACK: begin
          ack_go <= 1'b0;
          bit_cnt <= 3'h0;
          lstate <= L_WDATA;
        end
        L_RDATA: begin
          tx_sh <= {tx_sh[6:0], 1'b1};
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == 3'h7) begin
            lstate <= L_RACK;
          end
        end
        L_RACK: begin
          bit_cnt <= 3'h0;
          // Master acknowledge asks for the same byte again, refreshed
          if (!sda_i) begin
            lstate <= L_RDATA;
            tx_sh <= rd_hold;
          end else begin
            lstate <= L_IDLE;
          end
        end
        default: begin
          lstate <= L_IDLE;
        end
      endcase
    end
  end

  // Data enable changes only while the clock is low
  always_ff @(negedge scl_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sda_oe_o <= 1'b0;
    end else begin
      unique case (lstate)
        L_ADDR_ACK, L_CMD_ACK, L_WDATA_ACK: sda_oe_o <= ack_go;
        L_RDATA: sda_oe_o <= ~tx_sh[7];
        default: sda_oe_o <= 1'b0;
      endcase
    end
  end

  // Requests to the register side: held word plus a toggle
  always_ff @(posedge scl_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      req_tgl <= 1'b0;
      req_bus <= '0;
    end else if (byte_done && lstate == L_CMD) begin
      req_bus.kind <= REQ_SELECT;
      req_bus.op <= rx_byte[CMD_OP_LSB +: 3];
      req_bus.pot <= rx_byte[CMD_POT_LSB +: POT_W];
      req_bus.idx <= rx_byte[CMD_IDX_LSB +: IDX_W];
      req_bus.data <= 8'h00;
      req_tgl <= ~req_tgl;
    end else if (byte_done && lstate == L_WDATA) begin
      req_bus.kind <= REQ_WRITE;
      req_bus.data <= rx_byte;
      req_tgl <= ~req_tgl;
    end
  end

  // Reply toggle back into the serial clock domain
  qpw_sync2 #(.W(1)) u_ack_sync (
    .clk_i(scl_i),
    .rst_i(1'b0),
    .d_i(ack_tgl),
    .q_o(ack_tgl_s)
  );

  // Take the read byte only after its toggle arrived, so it is settled
  always_ff @(posedge scl_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ack_seen <= 1'b0;
      rd_hold <= 8'hff;
    end else if (ack_tgl_s != ack_seen) begin
      ack_seen <= ack_tgl_s;
      rd_hold <= rd_byte;
    end
  end

  // Write guard and request toggle into the system clock domain
  qpw_sync2 #(.W(1)) u_guard_sync (
    .clk_i(sys_clk_i),
    .rst_i(sys_rst_i),
    .d_i(wr_guard_n_i),
    .q_o(guard_n_s)
  );

  qpw_sync2 #(.W(1)) u_req_sync (
    .clk_i(sys_clk_i),
    .rst_i(sys_rst_i),
    .d_i(req_tgl),
    .q_o(req_tgl_s)
  );

  assign req_fire = req_tgl_s ^ req_seen;
  assign nv_allow = guard_n_s;

  // Decode one request against the addressed pot and slot
  always_comb begin
    cur_wiper = wiper_pos_o[req_bus.pot];
    cur_saved = saved[req_bus.pot][req_bus.idx];
    next_wiper = cur_wiper;
    next_saved = cur_saved;
    next_rd = cur_wiper;
    wiper_we = 1'b0;
    saved_we = 1'b0;
    if (req_bus.kind == REQ_SELECT) begin
      // Selection prefetches the byte a following read returns
      unique case (req_bus.op)
        OP_WIPER, OP_STEP: next_rd = cur_wiper;
        OP_SAVED: next_rd = cur_saved;
        OP_RECALL: begin
          wiper_we = 1'b1;
          next_wiper = cur_saved;
          next_rd = cur_saved;
        end
        OP_STORE: begin
          saved_we = nv_allow;
          next_saved = cur_wiper;
          next_rd = cur_wiper;
        end
        default: next_rd = 8'hff;
      endcase
    end else begin
      unique case (req_bus.op)
        OP_WIPER: begin
          wiper_we = 1'b1;
          next_wiper = req_bus.data;
          next_rd = req_bus.data;
        end
        OP_SAVED: begin
          saved_we = nv_allow;
          next_saved = req_bus.data;
          next_rd = nv_allow ? req_bus.data : cur_saved;
        end
        OP_STEP: begin
          // Step saturates at both ends rather than wrapping
          wiper_we = 1'b1;
          if (req_bus.data[0]) begin
            next_wiper = (cur_wiper == 8'hff) ? cur_wiper : cur_wiper + 8'h01;
          end else begin
            next_wiper = (cur_wiper == 8'h00) ? cur_wiper : cur_wiper - 8'h01;
          end
          next_rd = next_wiper;
        end
        default: next_rd = 8'hff;
      endcase
    end
  end

  // Request bookkeeping and reply toggle
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      req_seen <= 1'b0;
      ack_tgl <= 1'b0;
      rd_byte <= 8'hff;
    end else if (req_fire) begin
      req_seen <= req_tgl_s;
      rd_byte <= next_rd;
      ack_tgl <= ~ack_tgl;
    end
  end

  // Wiper position registers; power-up loads the first saved setting
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      for (int p = 0; p < NUM_POTS; p++) begin
        wiper_pos_o[p] <= nv_blank_i ? SAVED_BLANK : saved[p][0];
      end
    end else if (req_fire && wiper_we) begin
      wiper_pos_o[req_bus.pot] <= next_wiper;
    end
  end

  // Saved settings keep their contents through reset unless blanked
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i && nv_blank_i) begin
      for (int p = 0; p < NUM_POTS; p++) begin
        for (int i = 0; i < NUM_SAVED; i++) begin
          saved[p][i] <= SAVED_BLANK;
        end
      end
    end else if (!sys_rst_i && req_fire && saved_we) begin
      saved[req_bus.pot][req_bus.idx] <= next_saved;
    end
  end

  // One-hot tap select, one cycle behind the wiper register
  always_ff @(posedge sys_clk_i) begin
    for (int p = 0; p < NUM_POTS; p++) begin
      tap_sel_o[p] <= {{(NUM_TAPS-1){1'b0}}, 1'b1} << wiper_pos_o[p];
    end
  end

endmodule

`default_nettype wire

/* File: tb/qpw_master_model.sv */
`timescale 1ns/1ps
`default_nettype none

module qpw_master_model (
  // Serial bus; data wire pulled low while pull is set
  output logic scl_o,
  output logic sda_pull_o,
  input wire logic sda_i
);
  localparam int HP = 24;

  // Clock stands high outside frames
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end

  // Start or repeated start: data falls while clock high
  task automatic start();
    sda_pull_o = 1'b0;
    #HP scl_o = 1'b1;
    #HP sda_pull_o = 1'b1;
    #HP scl_o = 1'b0;
  endtask

  // Data moves only while clock is low, read just before the rise
  task automatic bit_io(input logic b, output logic r);
    #1 sda_pull_o = !b;
    #(HP-1) r = sda_i;
    scl_o = 1'b1;
    #HP scl_o = 1'b0;
  endtask

  // Byte out MSB first; ack true when the device pulls low
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask

  // Byte in; a low ninth bit asks for more
  task automatic get(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!more, r);
  endtask

  // Stop, then the bus rests released
  task automatic stop();
    #1 sda_pull_o = 1'b1;
    #HP scl_o = 1'b1;
    #HP sda_pull_o = 1'b0;
  endtask
endmodule

`default_nettype wire

/* File: tb/qpw_wiper_store_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

module qpw_wiper_store_chk import qpw_pkg::*; (
  // Clock, reset and bus
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic nv_blank_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  // Straps and guard
  input wire logic addr_strap_bit0_i,
  input wire logic addr_strap_bit1_i,
  input wire logic addr_strap_bit2_i,
  input wire logic addr_strap_bit3_i,
  input wire logic wr_guard_n_i,
  // Pot outputs
  input wire logic [NUM_POTS-1:0][POS_W-1:0] wiper_pos_o,
  input wire logic [NUM_POTS-1:0][NUM_TAPS-1:0] tap_sel_o
);
  logic [7:0] idle;
  logic scl_q;
  logic oe_rise;

  // Cycles since the last bus clock edge
  always_ff @(posedge sys_clk_i) begin
    scl_q <= scl_i;
    if (sys_rst_i || scl_i != scl_q) begin
      idle <= 8'h00;
    end else if (idle != 8'hff) begin
      idle <= idle + 8'h01;
    end
  end

  // Enable seen at each rise; cleared with the link
  always_ff @(posedge scl_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      oe_rise <= 1'b0;
    end else begin
      oe_rise <= sda_oe_o;
    end
  end

  chk_sda_drive_low: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) sda_o == 1'b0)
    else $error("data output not low");
  chk_idle_released: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    $fell(sys_rst_i) |-> !sda_oe_o) else $error("data wire held after reset");
  chk_oe_fall_only: assert property (@(negedge scl_i) disable iff (sys_rst_i)
    sda_oe_o == oe_rise) else $error("data enable moved while clock high");
  chk_wiper_bus_only: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    $changed(wiper_pos_o) |-> idle < 8'h10) else $error("wiper moved without bus");
  chk_tap_lag: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !$stable(wiper_pos_o) |=> !$stable(tap_sel_o)) else $error("tap did not follow wiper");
  chk_blank_load: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    $fell(sys_rst_i) && $past(nv_blank_i) |-> wiper_pos_o == {NUM_POTS{SAVED_BLANK}})
    else $error("blank value not loaded");
  chk_recall_hold: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    $fell(sys_rst_i) |-> $stable(wiper_pos_o)) else $error("wiper moved at release");
  // Every pot shows exactly the tap its wiper names
  for (genvar p = 0; p < NUM_POTS; p++) begin : g_pot
    chk_tap_match: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      tap_sel_o[p] == NUM_TAPS'(1) << $past(wiper_pos_o[p])) else $error("tap select wrong");
  end

  // Main scenarios reached
  cov_wiper_move: cover property (@(posedge sys_clk_i) $changed(wiper_pos_o));
  cov_ack: cover property (@(posedge sys_clk_i) $rose(sda_oe_o));
  cov_blank: cover property (@(posedge sys_clk_i) $fell(sys_rst_i) && $past(nv_blank_i));
endmodule

bind qpw_wiper_store qpw_wiper_store_chk i_qpw_wiper_store_chk (
  .sys_clk_i, .sys_rst_i, .nv_blank_i, .scl_i, .sda_i, .sda_o, .sda_oe_o,
  .addr_strap_bit0_i, .addr_strap_bit1_i, .addr_strap_bit2_i,
  .addr_strap_bit3_i, .wr_guard_n_i, .wiper_pos_o, .tap_sel_o
);

`default_nettype wire

/* File: tb/quad_pot_wiper_store_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module quad_pot_wiper_store_tb_top;
  import qpw_pkg::*;
  `define CK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
  logic clk = 1'b0;
  logic rst = 1'b0;
  logic blank = 1'b0;
  logic guard_n = 1'b1;
  logic [3:0] strap = 4'ha;
  logic [3:0] tgt = 4'ha;
  logic scl, pull, oe, ak;
  wire logic sda;
  logic [NUM_POTS-1:0][POS_W-1:0] wiper;
  logic [NUM_POTS-1:0][NUM_TAPS-1:0] taps;
  int miscompares = 0;
  int samples_checked = 0;

  // Clock, and a pulled-up wire low when any party pulls
  always #12.5 clk = !clk;
  assign sda = !(oe | pull);

  // Device and bus master
  qpw_wiper_store i_qpw_wiper_store (
    .sys_clk_i(clk), .sys_rst_i(rst), .nv_blank_i(blank), .scl_i(scl), .sda_i(sda),
    .sda_o(), .sda_oe_o(oe), .addr_strap_bit0_i(strap[0]), .addr_strap_bit1_i(strap[1]),
    .addr_strap_bit2_i(strap[2]), .addr_strap_bit3_i(strap[3]), .wr_guard_n_i(guard_n),
    .wiper_pos_o(wiper), .tap_sel_o(taps));
  qpw_master_model i_qpw_master_model (.scl_o(scl), .sda_pull_o(pull), .sda_i(sda));

  // Stored pattern per pot and slot
  function automatic logic [7:0] sv(input int p, input int x);
    return {p[1:0], x[1:0], 4'h6};
  endfunction

  task automatic do_reset(input logic bl);
    @(posedge clk);
    rst <= 1'b1;
    blank <= bl;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    blank <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // Recall and store carry no data byte
  task automatic wr(input logic [2:0] op, input int p, input int x, input logic [7:0] d);
    i_qpw_master_model.start();
    i_qpw_master_model.put({DEV_TYPE, tgt, 1'b0}, ak);
    `CK(ak, tgt == strap)
    if (ak) begin
      i_qpw_master_model.put({1'b0, op, 2'(p), 2'(x)}, ak);
      if (op != OP_RECALL && op != OP_STORE) i_qpw_master_model.put(d, ak);
    end
    i_qpw_master_model.stop();
    repeat (8) @(posedge clk);
  endtask

  task automatic rd(input logic [2:0] op, input int p, input int x, input logic [7:0] e);
    logic [7:0] d;
    i_qpw_master_model.start();
    i_qpw_master_model.put({DEV_TYPE, tgt, 1'b0}, ak);
    i_qpw_master_model.put({1'b0, op, 2'(p), 2'(x)}, ak);
    i_qpw_master_model.start();
    i_qpw_master_model.put({DEV_TYPE, tgt, 1'b1}, ak);
    i_qpw_master_model.get(1'b0, d);
    i_qpw_master_model.stop();
    `CK(d, e)
  endtask

  task automatic pot(input int p, input logic [7:0] v);
    `CK(wiper[p], v)
    `CK(taps[p], NUM_TAPS'(1) << v)
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Tests
  initial begin
    // A real rising edge, so the link side's async resets act before any clock
    rst <= 1'b1;
    do_reset(1'b1);
    for (int p = 0; p < NUM_POTS; p++) pot(p, SAVED_BLANK);
    for (int p = 0; p < NUM_POTS; p++) begin
      wr(OP_WIPER, p, 0, 8'(p * 85));
      pot(p, 8'(p * 85));
      rd(OP_WIPER, p, 0, 8'(p * 85));
    end
    wr(OP_STEP, 3, 0, 8'h01);
    pot(3, 8'hff);
    wr(OP_STEP, 0, 0, 8'h00);
    pot(0, 8'h00);
    wr(OP_STEP, 0, 0, 8'h01);
    pot(0, 8'h01);
    // All sixteen slots with the guard open
    for (int i = 0; i < 16; i++) wr(OP_SAVED, i / 4, i % 4, sv(i / 4, i % 4));
    for (int i = 0; i < 16; i++) rd(OP_SAVED, i / 4, i % 4, sv(i / 4, i % 4));
    @(posedge clk) guard_n <= 1'b0;
    repeat (4) @(posedge clk);
    wr(OP_SAVED, 1, 2, 8'hc4);
    wr(OP_STORE, 1, 2, 8'h00);
    rd(OP_SAVED, 1, 2, sv(1, 2));
    wr(OP_WIPER, 1, 0, 8'h7e);
    pot(1, 8'h7e);
    @(posedge clk) guard_n <= 1'b1;
    repeat (4) @(posedge clk);
    wr(OP_RECALL, 1, 2, 8'h00);
    pot(1, sv(1, 2));
    wr(OP_STORE, 2, 1, 8'h00);
    rd(OP_SAVED, 2, 1, 8'haa);
    rd(3'h5, 0, 0, 8'hff);
    // Foreign target ignored, then a new strap value
    tgt = 4'h5;
    wr(OP_WIPER, 0, 0, 8'h99);
    pot(0, 8'h01);
    @(posedge clk) strap <= 4'h5;
    wr(OP_WIPER, 0, 0, 8'h99);
    pot(0, 8'h99);
    do_reset(1'b0);
    for (int p = 0; p < NUM_POTS; p++) pot(p, sv(p, 0));
    conclude();
  end

  // Watchdog against a hung bus
  initial begin
    #1_000_000;
    miscompares++;
    conclude();
  end
endmodule

`default_nettype wire
